// ### hw/scsevq_consts.svh
// Constants for the SCSI host event queue block
`ifndef SCSEVQ_CONSTS_SVH
`define SCSEVQ_CONSTS_SVH
// Register byte offsets
`define SCSEVQ_OFF_CTRL 12'h000
`define SCSEVQ_OFF_STATUS 12'h004
`define SCSEVQ_OFF_FEAT_OFFER_LO 12'h008
`define SCSEVQ_OFF_FEAT_OFFER_HI 12'h00C
`define SCSEVQ_OFF_FEAT_DRV_LO 12'h010
`define SCSEVQ_OFF_FEAT_DRV_HI 12'h014
`define SCSEVQ_OFF_AN_SUBSCRIBED 12'h018
`define SCSEVQ_OFF_EVT_CODE 12'h01C
`define SCSEVQ_OFF_EVT_LUN_LO 12'h020
`define SCSEVQ_OFF_EVT_LUN_HI 12'h024
`define SCSEVQ_OFF_EVT_REASON 12'h028
`define SCSEVQ_OFF_EVT_LEN 12'h02C
`define SCSEVQ_OFF_BUF_POST 12'h030
`define SCSEVQ_OFF_DROP_COUNT 12'h034
// Control register bit positions
`define SCSEVQ_CTRL_LEGACY 0
`define SCSEVQ_CTRL_FEAT_OK 1
`define SCSEVQ_CTRL_UA_CLEAR 2
// Status register bit positions
`define SCSEVQ_STAT_LOST 0
`define SCSEVQ_STAT_REC_VALID 1
`define SCSEVQ_STAT_UA 2
`define SCSEVQ_STAT_EMPTY_IRQ 3
`define SCSEVQ_STAT_FAILED 4
`define SCSEVQ_STAT_BUFS_LSB 8
// Event codes and flags
`define SCSEVQ_NO_EVENT_CODE 32'h0000_0000
`define SCSEVQ_TRANSPORT_RESET_CODE 32'h0000_0001
`define SCSEVQ_ASYNC_NOTIFY_EVENT_CODE 32'h0000_0002
`define SCSEVQ_LUN_PARAM_CHANGE_EVENT_CODE 32'h0000_0003
`define SCSEVQ_EVENTS_LOST_FLAG 32'h8000_0000
// Transport reset reasons
`define SCSEVQ_RESET_REASON_HARD 32'h0000_0000
`define SCSEVQ_RESET_REASON_RESCAN 32'h0000_0001
`define SCSEVQ_RESET_REASON_REMOVED 32'h0000_0002
// Inquiry device type of multimedia units
`define SCSEVQ_MMC_DEV_TYPE 5'h05
// Feature bit positions in the 64-bit feature word
`define SCSEVQ_F_NOTIFY_EMPTY 24
`define SCSEVQ_F_ANY_LAYOUT 27
`define SCSEVQ_F_INDIRECT 28
`define SCSEVQ_F_EVENT_IDX 29
`define SCSEVQ_F_UNUSED30 30
`define SCSEVQ_F_HOTPLUG 1
`define SCSEVQ_F_VERSION_1 32
// Record size in bytes: 4 + 8 + 4
`define SCSEVQ_REC_BYTES 32'h0000_0010
// Posted buffer counter width
`define SCSEVQ_BUF_CNT_W 6
`endif

// ### hw/scsevq_pkg.sv
// Types shared by the SCSI host event queue block
`default_nettype none
package scsevq_pkg;
  // Kinds of event the host side raises
  typedef enum logic [1:0] {
    SCSEVQ_KIND_RESET = 2'b00,
    SCSEVQ_KIND_ASYNC = 2'b01,
    SCSEVQ_KIND_PARAM = 2'b10,
    SCSEVQ_KIND_NONE = 2'b11
  } scsevq_kind_t;
  // One event request from the host logic
  typedef struct packed {
    scsevq_kind_t kind;
    logic [63:0] lun;
    logic [31:0] detail;
    logic [4:0] dev_type;
  } scsevq_req_t;
  // One event record as written into a buffer
  typedef struct packed {
    logic [31:0] code;
    logic [63:0] lun;
    logic [31:0] reason;
  } scsevq_rec_t;
  // Writer states
  typedef enum logic [1:0] {
    SCSEVQ_IDLE = 2'b00,
    SCSEVQ_DONE = 2'b01
  } scsevq_state_t;
endpackage : scsevq_pkg
`default_nettype wire

// ### hw/scsevq_swap32.sv
// Byte order selector for one 32-bit record field
`default_nettype none
module scsevq_swap32 (
  // Control
  input wire logic native_be,
  // Data
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  // Reverse bytes when the guest is big-endian under the legacy interface
  always_comb
  begin
    if (native_be)
      dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
    else
      dout = din;
  end
endmodule // scsevq_swap32
`default_nettype wire

// ### hw/scsevq_top.sv
// SCSI host event queue: event record writer and feature negotiation
//
// What this block does
// - Async event gives record code two
// - Async reason masked by subscribed events
// - Parameter change gives record code three
// - ASC bits 0-7, ASCQ bits 8-15
// - Parameter change also raises unit attention
// - No parameter change for type five units
// - Lost events flag bit 31 later
// - Removed/rescan only with hot-plug negotiated
// - Legacy records in guest native order
// - Bit 28 allows indirect descriptors
// - Bit 29 enables event index fields
// - Device always offers bit 32
// - Bit 24: interrupt when buffers run out
// - Transitional device offers bit 27
// - Bit 30 never negotiated
// - Record: code, 8-byte LUN, reason
// - No-event code zero, flag 0x80000000
// - No internal queue; drop when no buffer
//
// The placing of the registers and the APB register port were chosen for this implementation.
`include "scsevq_consts.svh"
`default_nettype none
module scsevq_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event requests from host logic
  input wire logic evt_valid,
  input wire scsevq_pkg::scsevq_req_t evt_req,
  // Completed record and status
  output logic rec_pulse,
  output logic empty_irq,
  output logic unit_attention
);
  // Negotiation and control state
  logic legacy_reg; // Legacy interface, big-endian guest
  logic feat_ok_reg; // Driver has finished negotiation
  logic [31:0] drv_lo_reg; // Driver-accepted features 31:0
  logic [31:0] drv_hi_reg; // Driver-accepted features 63:32
  logic [31:0] subscribed_reg; // Async notification subscription mask
  logic [`SCSEVQ_BUF_CNT_W-1:0] bufs_reg; // Posted buffers available
  logic lost_reg; // Events dropped, flag not yet delivered
  logic [31:0] drop_cnt_reg; // Count of dropped events
  scsevq_pkg::scsevq_rec_t rec_reg; // Last record written
  logic rec_valid_reg; // A record is held
  logic ua_reg; // Unit attention pending
  logic empty_irq_reg; // Out-of-buffers interrupt
  // APB response flops and the record pulse flop
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic rec_pulse_reg;
  // Offered feature word: version one, any layout, indirect, event index,
  // notify on empty and hot-plug; bit 30 never offered
  // Bit 30 stays out of the offer so that it can never be negotiated,
  // and the driver's copy is masked by the offer before any use
  localparam logic [63:0] OFFER = (64'h0000_0001 << `SCSEVQ_F_VERSION_1)
    | (64'h0000_0001 << `SCSEVQ_F_ANY_LAYOUT)
    | (64'h0000_0001 << `SCSEVQ_F_INDIRECT)
    | (64'h0000_0001 << `SCSEVQ_F_EVENT_IDX)
    | (64'h0000_0001 << `SCSEVQ_F_NOTIFY_EMPTY)
    | (64'h0000_0001 << `SCSEVQ_F_HOTPLUG);
  // Negotiated features: only what was both offered and accepted
  logic [63:0] negotiated;
  assign negotiated = {drv_hi_reg, drv_lo_reg} & OFFER;
  logic hotplug_on;
  assign hotplug_on = feat_ok_reg & negotiated[`SCSEVQ_F_HOTPLUG];
  logic empty_on;
  assign empty_on = feat_ok_reg & negotiated[`SCSEVQ_F_NOTIFY_EMPTY];
  // Driver refused version one: device stops emitting events
  logic failed;
  assign failed = feat_ok_reg & ~negotiated[`SCSEVQ_F_VERSION_1];
  // APB decode
  // Every access takes exactly one wait-free access cycle: pready rises
  // in the cycle after setup, whatever the address
  // Writes land only at the access edge, when pready is high
  logic wr_en;
  assign wr_en = psel & penable & pwrite & pready_reg;
  logic rd_setup;
  assign rd_setup = psel & ~penable;
  logic mapped;
  always_comb
  begin
    case (paddr)
      `SCSEVQ_OFF_CTRL, `SCSEVQ_OFF_STATUS, `SCSEVQ_OFF_FEAT_OFFER_LO,
      `SCSEVQ_OFF_FEAT_OFFER_HI, `SCSEVQ_OFF_FEAT_DRV_LO, `SCSEVQ_OFF_FEAT_DRV_HI,
      `SCSEVQ_OFF_AN_SUBSCRIBED, `SCSEVQ_OFF_EVT_CODE, `SCSEVQ_OFF_EVT_LUN_LO,
      `SCSEVQ_OFF_EVT_LUN_HI, `SCSEVQ_OFF_EVT_REASON, `SCSEVQ_OFF_EVT_LEN,
      `SCSEVQ_OFF_BUF_POST, `SCSEVQ_OFF_DROP_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // Build the candidate record and decide whether it is legal
  scsevq_pkg::scsevq_rec_t cand;
  logic cand_ok;
  always_comb
  begin
    cand.lun = evt_req.lun;
    cand.reason = 32'h0000_0000;
    cand.code = `SCSEVQ_NO_EVENT_CODE;
    cand_ok = 1'b1;
    case (evt_req.kind)
      scsevq_pkg::SCSEVQ_KIND_RESET:
      begin
        cand.code = `SCSEVQ_TRANSPORT_RESET_CODE;
        cand.reason = evt_req.detail;
        // Removed and rescan need hot-plug negotiated
        if (evt_req.detail != `SCSEVQ_RESET_REASON_HARD && !hotplug_on)
          cand_ok = 1'b0;
        // Reasons above removed are refused outright
        if (evt_req.detail != `SCSEVQ_RESET_REASON_HARD && evt_req.detail != `SCSEVQ_RESET_REASON_RESCAN
            && evt_req.detail != `SCSEVQ_RESET_REASON_REMOVED)
          cand_ok = 1'b0;
      end
      scsevq_pkg::SCSEVQ_KIND_ASYNC:
      begin
        cand.code = `SCSEVQ_ASYNC_NOTIFY_EVENT_CODE;
        cand.reason = evt_req.detail & subscribed_reg;
      end
      scsevq_pkg::SCSEVQ_KIND_PARAM:
      begin
        cand.code = `SCSEVQ_LUN_PARAM_CHANGE_EVENT_CODE;
        // Detail carries the sense code in its low byte, qualifier above it
        cand.reason = {16'h0000, evt_req.detail[15:8], evt_req.detail[7:0]};
        if (evt_req.dev_type == `SCSEVQ_MMC_DEV_TYPE)
          cand_ok = 1'b0;
      end
      scsevq_pkg::SCSEVQ_KIND_NONE:
      begin
        // No-event is only worth sending when it carries the lost flag
        cand_ok = lost_reg;
      end
      default: cand_ok = 1'b0;
    endcase
    // A driver that refused version one gets no more records
    if (failed)
      cand_ok = 1'b0;
  end
  // A record is written when a legal event meets a posted buffer
  // Only legal events can be dropped; a refused event never sets the latch
  logic have_buf;
  assign have_buf = (bufs_reg != '0);
  logic take;
  assign take = evt_valid & cand_ok & have_buf;
  logic drop;
  assign drop = evt_valid & cand_ok & ~have_buf;
  // Auto no-event carrier once a buffer appears after a drop
  // It waits for a cycle with no request so that it never competes
  // with a real event for the same buffer
  logic carry_lost;
  assign carry_lost = lost_reg & have_buf & ~take & ~evt_valid & ~failed;
  logic post;
  assign post = wr_en & (paddr == `SCSEVQ_OFF_BUF_POST) & pwdata[0];
  // Byte order of written fields
  // Under the legacy interface the code and reason words follow the
  // guest's order; the LUN is a byte array and keeps its order
  logic [31:0] code_out;
  logic [31:0] reason_out;
  logic [31:0] code_raw;
  assign code_raw = take ? (cand.code | (lost_reg ? `SCSEVQ_EVENTS_LOST_FLAG : 32'h0000_0000))
                         : (`SCSEVQ_NO_EVENT_CODE | `SCSEVQ_EVENTS_LOST_FLAG);
  // One swapper per 32-bit field
  scsevq_swap32 u_swap_code (
    .native_be(legacy_reg),
    .din(code_raw),
    .dout(code_out)
  );
  scsevq_swap32 u_swap_reason (
    .native_be(legacy_reg),
    .din(take ? cand.reason : 32'h0000_0000),
    .dout(reason_out)
  );
  // Control register, driver feature words and subscription, written by software
  // The unit attention clear bit is a strobe and is not stored
  // The features-ok bit gates every negotiated feature
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      legacy_reg <= 1'b0;
      feat_ok_reg <= 1'b0;
      drv_lo_reg <= 32'h0000_0000;
      drv_hi_reg <= 32'h0000_0000;
      subscribed_reg <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `SCSEVQ_OFF_CTRL:
        begin
          legacy_reg <= pwdata[`SCSEVQ_CTRL_LEGACY];
          feat_ok_reg <= pwdata[`SCSEVQ_CTRL_FEAT_OK];
        end
        `SCSEVQ_OFF_FEAT_DRV_LO: drv_lo_reg <= pwdata;
        `SCSEVQ_OFF_FEAT_DRV_HI: drv_hi_reg <= pwdata;
        `SCSEVQ_OFF_AN_SUBSCRIBED: subscribed_reg <= pwdata;
        default: ;
      endcase
    end
  end
  // Posted buffer count: post adds, each record consumes one
  // A post and a consumed buffer in one cycle cancel out; a post to a
  // full counter is lost rather than wrapping the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bufs_reg <= '0;
    else
    begin
      case ({post && !(&bufs_reg), take || carry_lost})
        2'b10: bufs_reg <= bufs_reg + 1'b1;
        2'b01: bufs_reg <= bufs_reg - 1'b1;
        default: ;
      endcase
    end
  end
  // Lost-events latch; a new drop wins over the clearing record
  // The flag rides on the next record of any kind, then the latch clears
  // Drop has priority over the clear, so no loss is ever forgotten
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lost_reg <= 1'b0;
    else if (drop)
      lost_reg <= 1'b1;
    else if (take || carry_lost)
      lost_reg <= 1'b0;
  end
  // Dropped event counter
  // Wraps at its full range; software reads it only as a hint
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drop_cnt_reg <= 32'h0000_0000;
    else if (drop)
      drop_cnt_reg <= drop_cnt_reg + 32'h0000_0001;
  end
  // Record capture: the buffer returns with the record length
  // The automatic record carries no LUN and no reason
  // rec_pulse marks the buffer handed back to the driver
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_reg <= '0;
      rec_valid_reg <= 1'b0;
      rec_pulse_reg <= 1'b0;
    end
    else
    begin
      rec_pulse_reg <= take | carry_lost;
      if (take || carry_lost)
      begin
        rec_reg.code <= code_out;
        rec_reg.lun <= take ? cand.lun : 64'h0000_0000;
        rec_reg.reason <= reason_out;
        rec_valid_reg <= 1'b1;
      end
    end
  end
  // Unit attention for parameter changes; new event wins over clear
  // Software clears it through the control register strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ua_reg <= 1'b0;
    else if (take && evt_req.kind == scsevq_pkg::SCSEVQ_KIND_PARAM)
      ua_reg <= 1'b1;
    else if (wr_en && paddr == `SCSEVQ_OFF_CTRL && pwdata[`SCSEVQ_CTRL_UA_CLEAR])
      ua_reg <= 1'b0;
  end
  // Out-of-buffers interrupt when notify-on-empty is negotiated
  // Set when the last posted buffer is consumed; a new post clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      empty_irq_reg <= 1'b0;
    else if (empty_on && (take || carry_lost) && bufs_reg == 6'h01)
      empty_irq_reg <= 1'b1;
    else if (post)
      empty_irq_reg <= 1'b0;
  end
  // APB response: no wait states, read data captured in the setup cycle
  // pslverr flags an unmapped address in the same access cycle
  // Reads of write-only words return zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready_reg <= rd_setup;
      pslverr <= rd_setup & ~mapped;
      if (rd_setup)
      begin
        case (paddr)
          `SCSEVQ_OFF_CTRL: prdata_reg <= {30'h0000_0000, feat_ok_reg, legacy_reg};
          `SCSEVQ_OFF_STATUS: prdata_reg <= {18'h0_0000, bufs_reg, 3'h0, failed, empty_irq_reg,
                                             ua_reg, rec_valid_reg, lost_reg};
          `SCSEVQ_OFF_FEAT_OFFER_LO: prdata_reg <= OFFER[31:0];
          `SCSEVQ_OFF_FEAT_OFFER_HI: prdata_reg <= OFFER[63:32];
          `SCSEVQ_OFF_FEAT_DRV_LO: prdata_reg <= drv_lo_reg;
          `SCSEVQ_OFF_FEAT_DRV_HI: prdata_reg <= drv_hi_reg;
          `SCSEVQ_OFF_AN_SUBSCRIBED: prdata_reg <= subscribed_reg;
          `SCSEVQ_OFF_EVT_CODE: prdata_reg <= rec_reg.code;
          `SCSEVQ_OFF_EVT_LUN_LO: prdata_reg <= rec_reg.lun[31:0];
          `SCSEVQ_OFF_EVT_LUN_HI: prdata_reg <= rec_reg.lun[63:32];
          `SCSEVQ_OFF_EVT_REASON: prdata_reg <= rec_reg.reason;
          `SCSEVQ_OFF_EVT_LEN: prdata_reg <= rec_valid_reg ? `SCSEVQ_REC_BYTES : 32'h0000_0000;
          `SCSEVQ_OFF_DROP_COUNT: prdata_reg <= drop_cnt_reg;
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Outputs straight from flip-flops
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign rec_pulse = rec_pulse_reg;
  assign empty_irq = empty_irq_reg;
  assign unit_attention = ua_reg;
endmodule // scsevq_top
`default_nettype wire

// ### sim/scsevq_chk.sv
// Checker for the event queue block, bound to its top module
`include "scsevq_consts.svh"
`default_nettype none
module scsevq_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and status
  input wire logic evt_valid,
  input wire scsevq_pkg::scsevq_req_t evt_req,
  input wire logic rec_pulse,
  input wire logic empty_irq,
  input wire logic unit_attention
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] drv_lo_reg; // Driver feature word as last written
  logic feat_ok_reg; // Features accepted flag
  wire logic acc_w = psel && penable && pready && pwrite; // Write takes effect
  wire logic param_w = evt_valid && evt_req.kind == scsevq_pkg::SCSEVQ_KIND_PARAM; // Parameter change request
  // Shadow of the negotiation writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv_lo_reg <= 32'h0000_0000;
      feat_ok_reg <= 1'b0;
    end
    else if (acc_w && paddr == `SCSEVQ_OFF_FEAT_DRV_LO)
      drv_lo_reg <= pwdata;
    else if (acc_w && paddr == `SCSEVQ_OFF_CTRL)
      feat_ok_reg <= pwdata[`SCSEVQ_CTRL_FEAT_OK];
  end
  // Completed read access at one address
  sequence s_rd(logic [11:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  // Parameter change request for a multimedia unit
  sequence s_mmc;
    evt_valid && evt_req.kind == scsevq_pkg::SCSEVQ_KIND_PARAM && evt_req.dev_type == `SCSEVQ_MMC_DEV_TYPE;
  endsequence
  AST_V1_OFFERED: assert property (s_rd(`SCSEVQ_OFF_FEAT_OFFER_HI) |-> prdata[0])
    else $error("version one bit not offered");
  AST_BIT30_CLEAR: assert property (s_rd(`SCSEVQ_OFF_FEAT_OFFER_LO) |-> !prdata[30])
    else $error("bit 30 offered");
  AST_LAYOUT_OFFERED: assert property (s_rd(`SCSEVQ_OFF_FEAT_OFFER_LO) |-> prdata[27])
    else $error("layout bit not offered");
  AST_RING_BITS: assert property (s_rd(`SCSEVQ_OFF_FEAT_OFFER_LO) |-> prdata[29:28] == 2'b11)
    else $error("ring feature bits not offered");
  AST_NO_MMC_PARAM: assert property (s_mmc |=> !rec_pulse)
    else $error("parameter change record for multimedia unit");
  AST_HOTPLUG_ONLY: assert property (evt_valid && evt_req.kind == scsevq_pkg::SCSEVQ_KIND_RESET
    && evt_req.detail inside {`SCSEVQ_RESET_REASON_RESCAN, `SCSEVQ_RESET_REASON_REMOVED}
    && !(feat_ok_reg && drv_lo_reg[`SCSEVQ_F_HOTPLUG]) |=> !rec_pulse)
    else $error("hot plug record without negotiation");
  AST_UA_SET: assert property (rec_pulse && $past(param_w) |-> unit_attention)
    else $error("parameter change without unit attention");
  AST_UA_CAUSE: assert property ($rose(unit_attention) |-> rec_pulse)
    else $error("unit attention without record");
  AST_EMPTY_IRQ: assert property ($rose(empty_irq) |-> drv_lo_reg[24] && (rec_pulse || $past(rec_pulse)))
    else $error("empty interrupt without cause");
endmodule // scsevq_chk
bind scsevq_top scsevq_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .evt_valid, .evt_req, .rec_pulse, .empty_irq, .unit_attention);
`default_nettype wire

// ### sim/scsevq_drv.sv
// Guest driver model: APB master that negotiates and posts buffers
`include "scsevq_consts.svh"
`default_nettype none
module scsevq_drv (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer: setup, then access held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Post one writable record-sized buffer
  task post;
    logic [31:0] q;
    logic e;
    xfer(1'b1, `SCSEVQ_OFF_BUF_POST, 32'h0000_0001, q, e);
  endtask
  // Accept version one and empty interrupt, hot plug on request, never bit 30
  task negotiate(input logic hp);
    logic [31:0] q;
    logic e;
    // Any layout accepted, so the legacy single-descriptor framing limit never applies
    xfer(1'b1, `SCSEVQ_OFF_FEAT_DRV_LO, {4'h0, 1'b1, 2'b00, 1'b1, 22'h00_0000, hp, 1'b0}, q, e);
    xfer(1'b1, `SCSEVQ_OFF_FEAT_DRV_HI, 32'h0000_0001, q, e);
    xfer(1'b1, `SCSEVQ_OFF_CTRL, 32'h0000_0002, q, e);
  endtask
  // Stand-in for a bus rescan: poll the status word for unit attention
  task rescan(output logic [31:0] s);
    logic e;
    xfer(1'b0, `SCSEVQ_OFF_STATUS, 32'h0000_0000, s, e);
  endtask
endmodule // scsevq_drv
`default_nettype wire

// ### sim/test_scsi_host_event_queue_features.sv
// Self-checking bench for the event queue block
`include "scsevq_consts.svh"
`default_nettype none
module test_scsi_host_event_queue_features;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    scsevq_pkg::scsevq_kind_t k;
    logic [31:0] d;
    logic [4:0] t;
    logic [31:0] c;
    logic [31:0] r;
  } scsevq_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, e, got, rec_pulse, empty_irq, unit_attention;
  logic evt_valid = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  scsevq_pkg::scsevq_req_t evt_req = '0;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Ordinary events with the record they should give
  scsevq_row_t rows [6] = '{
    '{scsevq_pkg::SCSEVQ_KIND_RESET, 32'h0000_0000, 5'h00, 32'h0000_0001, 32'h0000_0000},
    '{scsevq_pkg::SCSEVQ_KIND_RESET, 32'h0000_0001, 5'h00, 32'h0000_0001, 32'h0000_0001},
    '{scsevq_pkg::SCSEVQ_KIND_RESET, 32'h0000_0002, 5'h00, 32'h0000_0001, 32'h0000_0002},
    '{scsevq_pkg::SCSEVQ_KIND_ASYNC, 32'h0000_00FF, 5'h00, 32'h0000_0002, 32'h0000_0012},
    '{scsevq_pkg::SCSEVQ_KIND_ASYNC, 32'h0000_0010, 5'h05, 32'h0000_0002, 32'h0000_0010},
    '{scsevq_pkg::SCSEVQ_KIND_PARAM, 32'h5A5A_092A, 5'h00, 32'h0000_0003, 32'h0000_092A}};
  always #4 pclk = ~pclk;
  scsevq_drv drv (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  scsevq_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .evt_valid, .evt_req, .rec_pulse, .empty_irq, .unit_attention);
  // Verdict and end of run
  task test_done;
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compare one value
  task cmp(input string n, input logic [31:0] x, input logic [31:0] s);
    compares++;
    if (s !== x)
    begin
      $display("[FAIL] %s expected %h seen %h", n, x, s);
      err_count++;
    end
  endtask
  // Register read and write
  task rd(input logic [11:0] a);
    drv.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    drv.xfer(1'b1, a, d, q, e);
  endtask
  // One event request; record pulse sampled in the answer cycle
  task ev(input scsevq_pkg::scsevq_kind_t k, input logic [63:0] l, input logic [31:0] d, input logic [4:0] t);
    @(posedge pclk);
    evt_valid <= 1'b1;
    evt_req <= '{k, l, d, t};
    @(posedge pclk);
    evt_valid <= 1'b0;
    evt_req <= ~evt_req;
    #1 got = rec_pulse;
  endtask
  // Read back the held record
  task chk_rec(input logic [31:0] c, input logic [31:0] r, input logic [63:0] l);
    rd(`SCSEVQ_OFF_EVT_CODE);
    cmp("code", c, q);
    rd(`SCSEVQ_OFF_EVT_REASON);
    cmp("reason", r, q);
    rd(`SCSEVQ_OFF_EVT_LUN_LO);
    cmp("lun_lo", l[31:0], q);
    rd(`SCSEVQ_OFF_EVT_LUN_HI);
    cmp("lun_hi", l[63:32], q);
    rd(`SCSEVQ_OFF_EVT_LEN);
    cmp("len", `SCSEVQ_REC_BYTES, q);
  endtask
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      test_done;
    end
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`SCSEVQ_OFF_STATUS);
    cmp("status", 32'h0000_0000, q);
    rd(`SCSEVQ_OFF_FEAT_OFFER_LO);
    cmp("offer_lo", 32'h3900_0002, q);
    rd(`SCSEVQ_OFF_FEAT_OFFER_HI);
    cmp("offer_hi", 32'h0000_0001, q);
    rd(12'h100);
    cmp("unmapped_err", 32'h0000_0001, {31'h0, e});
    drv.negotiate(1'b1);
    wr(`SCSEVQ_OFF_AN_SUBSCRIBED, 32'h0000_0012);
    foreach (rows[i])
    begin
      drv.post;
      ev(rows[i].k, {32'h0100_4000 + 32'(i), 32'hA5A5_0000}, rows[i].d, rows[i].t);
      cmp("rec_pulse", 32'h0000_0001, {31'h0, got});
      chk_rec(rows[i].c, rows[i].r, {32'h0100_4000 + 32'(i), 32'hA5A5_0000});
    end
    cmp("unit_attention", 32'h0000_0001, {31'h0, unit_attention});
    cmp("empty_irq", 32'h0000_0001, {31'h0, empty_irq});
    wr(`SCSEVQ_OFF_CTRL, 32'h0000_0006);
    #1;
    cmp("ua_clear", 32'h0000_0000, {31'h0, unit_attention});
    ev(scsevq_pkg::SCSEVQ_KIND_ASYNC, 64'h0000_0000_0000_0007, 32'h0000_0002, 5'h00);
    cmp("dropped", 32'h0000_0000, {31'h0, got});
    rd(`SCSEVQ_OFF_DROP_COUNT);
    cmp("drop_count", 32'h0000_0001, q);
    rd(`SCSEVQ_OFF_STATUS);
    cmp("lost_set", 32'h0000_0001, {31'h0, q[0]});
    drv.post;
    got = 1'b0;
    for (int i = 0; i < 8 && got !== 1'b1; i++)
    begin
      @(posedge pclk);
      #1 got = rec_pulse;
    end
    cmp("auto_rec", 32'h0000_0001, {31'h0, got});
    chk_rec(`SCSEVQ_EVENTS_LOST_FLAG, 32'h0000_0000, 64'h0);
    drv.rescan(q);
    cmp("lost_clear", 32'h0000_0000, {31'h0, q[0]});
    cmp("ua_poll", 32'h0000_0000, {31'h0, q[2]});
    drv.post;
    ev(scsevq_pkg::SCSEVQ_KIND_PARAM, 64'h0000_0000_0000_0003, 32'h0000_092A, `SCSEVQ_MMC_DEV_TYPE);
    cmp("mmc_param", 32'h0000_0000, {31'h0, got});
    ev(scsevq_pkg::SCSEVQ_KIND_RESET, 64'h0, `SCSEVQ_RESET_REASON_RESCAN, 5'h00);
    cmp("rescan_lun0", 32'h0000_0001, {31'h0, got});
    drv.rescan(q);
    cmp("bufs_used", 32'h0000_0000, {26'h000_0000, q[13:8]});
    drv.post;
    drv.negotiate(1'b0);
    ev(scsevq_pkg::SCSEVQ_KIND_RESET, 64'h0, `SCSEVQ_RESET_REASON_RESCAN, 5'h00);
    cmp("rescan_no_hp", 32'h0000_0000, {31'h0, got});
    ev(scsevq_pkg::SCSEVQ_KIND_RESET, 64'h0, `SCSEVQ_RESET_REASON_REMOVED, 5'h00);
    cmp("removed_no_hp", 32'h0000_0000, {31'h0, got});
    ev(scsevq_pkg::SCSEVQ_KIND_RESET, 64'h0, `SCSEVQ_RESET_REASON_HARD, 5'h00);
    cmp("hard_no_hp", 32'h0000_0001, {31'h0, got});
    drv.post;
    wr(`SCSEVQ_OFF_CTRL, 32'h0000_0003);
    ev(scsevq_pkg::SCSEVQ_KIND_ASYNC, 64'h0000_0000_0000_0009, 32'h0000_0002, 5'h00);
    chk_rec(32'h0200_0000, 32'h0200_0000, 64'h0000_0000_0000_0009);
    wr(`SCSEVQ_OFF_FEAT_DRV_HI, 32'h0000_0000);
    drv.post;
    ev(scsevq_pkg::SCSEVQ_KIND_RESET, 64'h0, `SCSEVQ_RESET_REASON_HARD, 5'h00);
    cmp("v1_refused", 32'h0000_0000, {31'h0, got});
    rd(`SCSEVQ_OFF_STATUS);
    cmp("failed", 32'h0000_0001, {31'h0, q[4]});
    test_done;
  end
endmodule // test_scsi_host_event_queue_features
`default_nettype wire
